/* File: spi_master_slave_port_tb.sv */
// self-checking bench for the serial port core with a peer model
`default_nettype none

module spi_master_slave_port_tb
    import spimsp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic       core_clk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, sl = 1'b0;
    logic       arm = 1'b0, lead = 1'b0, clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, ptx = 8'h00, rdata, prx, v;
    logic       done, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, psck, pss_n, pdout;
    logic [31:0] rv;
    int         errors = 0, checks_done = 0, seed = 40, cyc = 0, ne, lastc, hp, gbad;
    wire logic  sck_w = sclk_oe ? sclk_o : psck;
    wire logic  miso_w = miso_oe ? miso_o : pdout;
    wire logic  mosi_w = mosi_oe ? mosi_o : pdout;

    always #50 core_clk_i = ~core_clk_i;

    spimsp_core DUT
    (
        .core_clk_i      (core_clk_i),
        .rst_n_i         (rst_n_i),
        .sfr_addr_i      (addr),
        .sfr_wr_i        (wr),
        .sfr_rd_i        (rd),
        .sfr_wdata_i     (wdata),
        .sfr_rdata_o     (rdata),
        .transfer_done_o (done),
        .sclk_i          (sck_w),
        .sclk_o          (sclk_o),
        .sclk_oe_o       (sclk_oe),
        .mosi_i          (mosi_w),
        .mosi_o          (mosi_o),
        .mosi_oe_o       (mosi_oe),
        .miso_i          (miso_w),
        .miso_o          (miso_o),
        .miso_oe_o       (miso_oe),
        .ss_n_i          (pss_n)
    );

    spimsp_peer peer
    (
        .clk_i  (core_clk_i),
        .arm_i  (arm),
        .lead_i (lead),
        .clock_polarity_bit_i (clock_polarity_bit),
        .clock_phase_bit_i (clock_phase_bit),
        .tx_i   (ptx),
        .sck_i  (sck_w),
        .din_i  (lead ? miso_w : mosi_w),
        .sck_o  (psck),
        .ss_n_o (pss_n),
        .dout_o (pdout),
        .rx_o   (prx)
    );

    // serial clock edge count and half-period check
    always @(posedge core_clk_i)
    begin
        #1;
        cyc = cyc + 1;
        if (sclk_o !== sl)
        begin
            if (ne > 0 && cyc - lastc != hp)
                gbad = gbad + 1;
            ne = ne + 1;
            lastc = cyc;
        end
        sl = sclk_o;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        {addr, wdata, wr} = {a, d, 1'b1};
        tick(1);
        wr = 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        tick(1);
        {addr, rd} = {a, 1'b1};
        tick(1);
        rd = 1'b0;
        d = rdata;
    endtask

    task automatic go();
        tick(1);
        arm = 1'b1;
        tick(1);
        arm = 1'b0;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 600)
        begin
            tick(1);
            n = n + 1;
        end
        chk("done", 8'h01, {7'h00, done});
    endtask

    // control word: done, collision, enable, master, polarity, phase, rate
    function automatic logic [7:0] ctrl_word(input logic dn, input logic cl, input logic ms,
                                             input logic pol, input logic pha, input logic [1:0] r);
        return {dn, cl, 1'b1, ms, pol, pha, r};
    endfunction

    task automatic mxfer(input logic [1:0] r, input logic pol, input logic pha, input logic col);
        logic [7:0] t, p, x;
        t = 8'($random(seed));
        p = 8'($random(seed));
        {lead, clock_polarity_bit, clock_phase_bit, ptx} = {1'b0, pol, pha, p};
        wreg(SPIMSP_ADDR_CTRL, ctrl_word(1'b0, 1'b0, 1'b1, pol, pha, r));
        go();
        hp = 1 << r;
        ne = 0;
        gbad = 0;
        wreg(SPIMSP_ADDR_DATA, t);
        if (col)
            tick(12);
        if (col)
            wreg(SPIMSP_ADDR_DATA, ~t);
        wait_done();
        tick(4);
        chk("sclk_idle", {7'h00, pol}, {7'h00, sclk_o});
        chk("oe", 8'h03, {6'h00, sclk_oe, mosi_oe});
        chk("edges", 8'h10, ne[7:0]);
        chk("gaps", 8'h00, gbad[7:0]);
        chk("peer_rx", t, prx);
        x = ctrl_word(1'b1, col, 1'b1, pol, pha, r);
        rreg(SPIMSP_ADDR_CTRL, v);
        chk("ctrl", x, v);
        rreg(SPIMSP_ADDR_DATA, v);
        chk("data", p, v);
        rreg(8'h55, v);
        chk("unmapped", p, v);
        rreg(SPIMSP_ADDR_CTRL, v);
        chk("ctrl_clr", {1'b0, x[6:0]}, v);
        $display("test master rate %0d done", r);
    endtask

    task automatic sxfer(input logic pol, input logic pha);
        logic [7:0] t, p;
        t = 8'($random(seed));
        p = 8'($random(seed));
        {lead, clock_polarity_bit, clock_phase_bit, ptx} = {1'b1, pol, pha, p};
        wreg(SPIMSP_ADDR_CTRL, ctrl_word(1'b0, 1'b0, 1'b0, pol, pha, 2'h0));
        wreg(SPIMSP_ADDR_DATA, t);
        rreg(SPIMSP_ADDR_CTRL, v);
        chk("ss_high", 8'h01, {7'h00, v[0]});
        chk("miso_off", 8'h00, {7'h00, miso_oe});
        go();
        tick(4);
        rreg(SPIMSP_ADDR_CTRL, v);
        chk("ss_low", 8'h00, {7'h00, v[0]});
        wait_done();
        chk("end_of_byte", {7'h00, ~pha}, {7'h00, pss_n});
        tick(24);
        chk("peer_rx", t, prx);
        chk("miso_idle", 8'h00, {7'h00, miso_oe});
        rreg(SPIMSP_ADDR_DATA, v);
        chk("data", p, v);
        $display("test slave mode %0d done", {pol, pha});
    endtask

    initial
    begin
        tick(5);
        rst_n_i = 1'b1;
        rreg(SPIMSP_ADDR_CTRL, v);
        chk("ctrl_reset", 8'h04, v);
        rreg(SPIMSP_ADDR_DATA, v);
        chk("data_reset", 8'h00, v);
        $display("test reset values done");
        for (int i = 0; i < 4; i++)
            mxfer(i[1:0], i[0], i[1], 1'b0);
        rv = $random(seed);
        mxfer(rv[1:0], rv[2], rv[3], 1'b0);
        mxfer(2'h3, 1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++)
            sxfer(i[0], i[1]);
        wreg(SPIMSP_ADDR_CTRL, 8'h10);
        tick(3);
        chk("pins_off", 8'h00, {5'h00, sclk_oe, mosi_oe, miso_oe});
        $display("test disabled port done");
        give_verdict();
    end

    initial
    begin
        #3_000_000;
        errors = errors + 1;
        give_verdict();
    end
endmodule

`default_nettype wire

/* File: spimsp_core.sv */
// byte-wide master/slave serial port with control and data registers
// Function
// - done flag set per byte; clear by write/read
// - data write while busy sets collision flag
// - enable bit off releases all serial pins
// - master bit drives clock; else clock input
// - polarity bit sets serial clock idle level
// - phase bit chooses launch edge; sample opposite
// - rate bits divide core clock by 2..16
// - slave read of bit0 returns select pin
// - data write sends, read returns received byte
// - master write starts exactly eight clock periods
// - master ignores select input pin
// - master shifts out and samples each period
// - master latches byte, sets done after eighth
// - slave sends written byte, one bit/period
// - slave latches at eighth clock or select rise
// - eight bits, most significant first
// - control register resets to 04h
`default_nettype none

module spimsp_core
    import spimsp_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    output logic            transfer_done_o,
    input  wire logic       sclk_i,
    output logic            sclk_o,
    output logic            sclk_oe_o,
    input  wire logic       mosi_i,
    output logic            mosi_o,
    output logic            mosi_oe_o,
    input  wire logic       miso_i,
    output logic            miso_o,
    output logic            miso_oe_o,
    input  wire logic       ss_n_i
);

    typedef struct packed {
        spimsp_ctl_type ctl;
        logic [7:0]     data;
        logic [7:0]     tx_sh;
        logic [7:0]     rx_sh;
        logic [7:0]     rdata;
        logic           busy;
        logic           stop;
        logic [3:0]     edge_cnt;
        logic [3:0]     bits;
        logic [1:0]     pipe;
        logic           sclk;
        logic           mosi;
        logic           miso;
        logic           sclk_oe;
        logic           mosi_oe;
        logic           miso_oe;
        logic           sclk_prev;
        logic           ss_prev;
    } spimsp_state_type;

    localparam spimsp_state_type ST_RESET = '{
        ctl:     spimsp_ctl_type'(SPIMSP_CTRL_RESET),
        data:    SPIMSP_DATA_RESET,
        default: '0
    };

    spimsp_state_type q;
    spimsp_state_type d;
    spimsp_rate_if    rif ();

    logic [3:0] pins_s;
    logic       sclk_s;
    logic       mosi_s;
    logic       miso_s;
    logic       ss_n_s;

    spimsp_pin_sync #(.W(4)) u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .pin_i      ({sclk_i, mosi_i, miso_i, ss_n_i}),
        .pin_o      (pins_s)
    );

    assign {sclk_s, mosi_s, miso_s, ss_n_s} = pins_s;

    spimsp_rate_div u_div (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .rif        (rif)
    );

    logic wr_data;
    logic wr_ctrl;
    logic rd_data;
    logic rd_ctrl;
    logic master_on;
    logic slave_on;
    logic ss_act;
    logic busy_any;
    logic m_edge;
    logic s_edge;
    logic leading;
    logic launch;
    logic out_bit;
    logic m_finish;

    assign rif.run  = q.busy && !q.stop;
    assign rif.rate = q.ctl.rate;

    always_comb
    begin
        d         = q;
        wr_data   = sfr_wr_i && (sfr_addr_i == SPIMSP_ADDR_DATA);
        wr_ctrl   = sfr_wr_i && (sfr_addr_i == SPIMSP_ADDR_CTRL);
        rd_data   = sfr_rd_i && (sfr_addr_i == SPIMSP_ADDR_DATA);
        rd_ctrl   = sfr_rd_i && (sfr_addr_i == SPIMSP_ADDR_CTRL);
        master_on = q.ctl.en && q.ctl.master;
        slave_on  = q.ctl.en && !q.ctl.master;
        ss_act    = slave_on && !ss_n_s;
        busy_any  = master_on ? q.busy : (slave_on && q.bits != 4'h0);
        m_edge    = master_on && q.busy && !q.stop && rif.tick;
        s_edge    = ss_act && (sclk_s != q.sclk_prev);
        leading   = master_on ? (q.sclk == q.ctl.clock_polarity_bit) : (sclk_s != q.ctl.clock_polarity_bit);
        launch    = (leading == q.ctl.clock_phase_bit);
        out_bit   = q.ctl.clock_phase_bit ? q.tx_sh[7] : q.tx_sh[6];
        m_finish  = master_on && q.busy && q.stop && q.bits == SPIMSP_BYTE_BITS && q.pipe == 2'b00;

        d.sclk_prev = sclk_s;
        d.ss_prev   = ss_n_s;
        d.pipe      = {q.pipe[0], 1'b0};

        // register writes first so that hardware sets below win
        if (wr_ctrl)
            d.ctl = spimsp_ctl_type'(sfr_wdata_i);
        if (rd_data)
            d.ctl.done = 1'b0;
        if (rd_ctrl)
        begin
            d.rdata = q.ctl;
            if (slave_on)
                d.rdata[SPIMSP_POS_RATE] = ss_n_s;
        end
        else if (rd_data)
        begin
            d.rdata = q.data;
        end

        if (wr_data)
        begin
            if (busy_any)
            begin
                d.ctl.coll = 1'b1;
            end
            else
            begin
                d.tx_sh = sfr_wdata_i;
                if (master_on)
                begin
                    d.busy     = 1'b1;
                    d.stop     = 1'b0;
                    d.edge_cnt = '0;
                    d.bits     = '0;
                    d.mosi     = sfr_wdata_i[7];
                end
            end
        end

        // master: toggle on each half period, sixteen edges
        if (m_edge)
        begin
            d.sclk     = !q.sclk;
            d.edge_cnt = 4'(q.edge_cnt + 4'h1);
            if (q.edge_cnt == SPIMSP_LAST_EDGE)
                d.stop = 1'b1;
            if (launch)
            begin
                d.mosi  = out_bit;
                d.tx_sh = {q.tx_sh[6:0], 1'b0};
            end
            else
            begin
                d.pipe[0] = 1'b1;
            end
        end
        // sample taken once the synchronised miso has settled
        if (master_on && q.pipe[1])
        begin
            d.rx_sh = {q.rx_sh[6:0], miso_s};
            d.bits  = 4'(q.bits + 4'h1);
        end
        if (m_finish)
        begin
            d.data     = q.rx_sh;
            d.ctl.done = 1'b1;
            d.busy     = 1'b0;
            d.stop     = 1'b0;
            d.bits     = '0;
        end
        if (!master_on || !q.busy)
            d.sclk = q.ctl.clock_polarity_bit;

        // slave: edges only count while selected
        if (slave_on)
        begin
            if (!ss_act)
            begin
                d.miso = q.tx_sh[7];
                d.bits = '0;
                if (!q.ctl.clock_phase_bit && !q.ss_prev && q.bits == SPIMSP_BYTE_BITS)
                begin
                    d.data     = q.rx_sh;
                    d.ctl.done = 1'b1;
                end
            end
            else if (s_edge && launch)
            begin
                d.miso  = out_bit;
                d.tx_sh = {q.tx_sh[6:0], 1'b0};
            end
            else if (s_edge)
            begin
                d.rx_sh = {q.rx_sh[6:0], mosi_s};
                d.bits  = 4'(q.bits + 4'h1);
                if (q.ctl.clock_phase_bit && q.bits == SPIMSP_BYTE_BITS - 4'h1)
                begin
                    d.data     = {q.rx_sh[6:0], mosi_s};
                    d.ctl.done = 1'b1;
                    d.bits     = '0;
                end
            end
        end

        d.sclk_oe = master_on;
        d.mosi_oe = master_on;
        d.miso_oe = ss_act;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            q <= ST_RESET;
        else
            q <= d;
    end

    assign sfr_rdata_o     = q.rdata;
    assign transfer_done_o = q.ctl.done;
    assign sclk_o          = q.sclk;
    assign sclk_oe_o       = q.sclk_oe;
    assign mosi_o          = q.mosi;
    assign mosi_oe_o       = q.mosi_oe;
    assign miso_o          = q.miso;
    assign miso_oe_o       = q.miso_oe;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_master_start;
        wr_data && master_on && !q.busy;
    endsequence

    sequence s_byte_done;
        q.ctl.done && !q.busy;
    endsequence

    a_done_set_end: assert property (m_finish |=> q.ctl.done && q.data == $past(q.rx_sh))
        else $error("done flag or data not taken at end of master byte");

    a_burst_len_fast: assert property ((s_master_start and (q.ctl.rate == 2'b00)) |->
                                       ##[18:24] s_byte_done)
        else $error("master byte at rate 0 did not finish in time");

    a_burst_edges: assert property (m_finish |-> q.edge_cnt == 4'h0 && q.stop)
        else $error("master finished without sixteen clock edges");

    a_coll_on_busy: assert property ((wr_data && busy_any) |=> q.ctl.coll)
        else $error("collision flag not set on busy write");

    a_coll_discard: assert property ((wr_data && busy_any && !m_edge && !s_edge) |=>
                                     q.tx_sh == $past(q.tx_sh))
        else $error("colliding write changed the transmit byte");

    a_read_clears: assert property ((rd_data && !m_finish && slave_on == 1'b0 && !wr_ctrl) |=>
                                    !q.ctl.done && sfr_rdata_o == $past(q.data))
        else $error("data read did not clear done flag or return byte");

    a_sclk_idle_lvl: assert property ((master_on && !q.busy && !wr_ctrl) ##1 !q.busy |->
                                      sclk_o == q.ctl.clock_polarity_bit)
        else $error("serial clock not at idle level");

    a_pins_release: assert property ((!q.ctl.en && !wr_ctrl) |=>
                                     !sclk_oe_o && !mosi_oe_o && !miso_oe_o)
        else $error("pins driven while port disabled");

    a_slave_miso_off: assert property ((slave_on && ss_n_s) |=> !miso_oe_o)
        else $error("miso driven while deselected");

    a_ss_readback: assert property ((rd_ctrl && slave_on) |=> sfr_rdata_o[0] == $past(ss_n_s))
        else $error("select level not returned in slave mode");

endmodule

`default_nettype wire

/* File: spimsp_peer.sv */
// behavioural peer device on the far side of the serial port, master or slave
`default_nettype none

module spimsp_peer
(
    input  wire logic       clk_i,
    input  wire logic       arm_i,
    input  wire logic       lead_i,
    input  wire logic       clock_polarity_bit_i,
    input  wire logic       clock_phase_bit_i,
    input  wire logic [7:0] tx_i,
    input  wire logic       sck_i,
    input  wire logic       din_i,
    output logic            sck_o,
    output logic            ss_n_o,
    output logic            dout_o,
    output logic      [7:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic a_s, k_s, d_s, last;
    int   ec = 16, hc = 0, idx;

    initial
    begin
        {sck_o, ss_n_o, dout_o, rx_o, last} = 12'h400;
    end

    // arm taken at the edge; pins read once settled, so the fastest rate still sees each bit in time
    always @(posedge clk_i)
    begin
        a_s = arm_i;
        #1;
        {k_s, d_s} = {sck_i, din_i};
        hc = hc + 1;
        if (a_s)
        begin
            ec = 0;
            hc = 0;
            sck_o = clock_polarity_bit_i;
            last = lead_i ? clock_polarity_bit_i : k_s;
            ss_n_o = ~lead_i;
            dout_o = tx_i[7];
        end
        else if (k_s !== last && ec < 16)
        begin
            last = k_s;
            idx = clock_phase_bit_i ? ec / 2 : (ec + 1) / 2;
            if (ec % 2 == int'(clock_phase_bit_i))
                rx_o = {rx_o[6:0], d_s};
            else if (idx < 8)
                dout_o = tx_i[7 - idx];
            ec = ec + 1;
        end
        // clock parked at its idle level outside frames, before select falls
        if (lead_i && ec < 16 && hc % 8 == 0 && hc > 0)
            sck_o = ~sck_o;
        else if (ec == 16)
            sck_o = clock_polarity_bit_i;
        if (lead_i && hc == 144)
            ss_n_o = 1'b1;
        // released line must not keep showing the last bit
        if (ec == 16 && hc > 160)
            dout_o = ~dout_o;
    end
endmodule

`default_nettype wire

/* File: spimsp_pin_sync.sv */
// two-stage synchroniser for the serial pins
`default_nettype none

module spimsp_pin_sync
    import spimsp_pkg::*;
#(
    parameter int W = 4
)
(
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] pin_o
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } spimsp_sync_type;

    spimsp_sync_type q;
    spimsp_sync_type d;

    always_comb
    begin
        d.stage1 = pin_i;
        d.stage2 = q.stage1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            q <= '0;
        else
            q <= d;
    end

    assign pin_o = q.stage2;

endmodule

`default_nettype wire

/* File: spimsp_pkg.sv */
// constants and types shared by the serial port design
`default_nettype none

package spimsp_pkg;

    // register addresses on the special-function bus
    localparam logic [7:0] SPIMSP_ADDR_DATA  = 8'hf7;
    localparam logic [7:0] SPIMSP_ADDR_CTRL  = 8'hf8;

    // control register field positions
    localparam int         SPIMSP_POS_DONE   = 7;
    localparam int         SPIMSP_POS_COLL   = 6;
    localparam int         SPIMSP_POS_EN     = 5;
    localparam int         SPIMSP_POS_MASTER = 4;
    localparam int         SPIMSP_POS_CLOCK_POLARITY_BIT   = 3;
    localparam int         SPIMSP_POS_CLOCK_PHASE_BIT   = 2;
    localparam int         SPIMSP_POS_RATE   = 0;

    // reset values
    localparam logic [7:0] SPIMSP_CTRL_RESET = 8'h04;
    localparam logic [7:0] SPIMSP_DATA_RESET = 8'h00;

    // timing and framing counts
    localparam logic [3:0] SPIMSP_BYTE_BITS  = 4'h8;
    localparam logic [3:0] SPIMSP_LAST_EDGE  = 4'hf;
    localparam logic [2:0] SPIMSP_DIV_ONE    = 3'h1;

    // control register image, bit 7 down to bit 0
    typedef struct packed {
        logic       done;
        logic       coll;
        logic       en;
        logic       master;
        logic       clock_polarity_bit;
        logic       clock_phase_bit;
        logic [1:0] rate;
    } spimsp_ctl_type;

endpackage

`default_nettype wire

/* File: spimsp_rate_div.sv */
// divider giving one tick per serial half period
`default_nettype none

module spimsp_rate_div
    import spimsp_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    spimsp_rate_if.div rif
);

    typedef struct packed {
        logic [2:0] cnt;
        logic       tick;
    } spimsp_div_type;

    spimsp_div_type q;
    spimsp_div_type d;
    logic [2:0]     half_last;

    // half period is 1, 2, 4 or 8 core cycles
    always_comb
    begin
        half_last = 3'((SPIMSP_DIV_ONE << rif.rate) - SPIMSP_DIV_ONE);
        d         = q;
        d.tick    = 1'b0;
        if (!rif.run)
        begin
            d.cnt = '0;
        end
        else if (q.cnt == half_last)
        begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end
        else
        begin
            d.cnt = 3'(q.cnt + 3'h1);
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            q <= '0;
        else
            q <= d;
    end

    assign rif.tick = q.tick;

endmodule

`default_nettype wire

/* File: spimsp_rate_if.sv */
// bit-rate request and tick between the port core and its divider
`default_nettype none

interface spimsp_rate_if;
    logic       run;
    logic [1:0] rate;
    logic       tick;

    modport core (output run, output rate, input tick);
    modport div  (input run, input rate, output tick);
endinterface

`default_nettype wire
